// *** pkg/rrs_pkg.sv ***
/*
 * Constants for the return, rotate and sleep execution block.
 * Assumes a 12-bit instruction word and an 8-bit data path.
 */
package rrs_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int unsigned INSTR_W    = 12;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned FADDR_W    = 5;
    localparam int unsigned IP_W       = 10;

    // ************************************************************
    // Instruction fields
    // ************************************************************
    localparam int unsigned RET_OP_LSB = 8;
    localparam int unsigned ROT_OP_LSB = 6;
    localparam int unsigned DEST_BIT   = 5;
    localparam int unsigned LIT_MSB    = 7;
    localparam int unsigned FADDR_MSB  = 4;

    // ************************************************************
    // Opcode patterns
    // ************************************************************
    localparam logic [3:0]  RET_OP     = 4'h8;
    localparam logic [5:0]  ROT_L_OP   = 6'h0D;
    localparam logic [5:0]  ROT_R_OP   = 6'h0C;
    localparam logic [11:0] SLEEP_OP   = 12'h003;

    // ************************************************************
    // Reset values
    // ************************************************************
    localparam logic [7:0]  ACC_RST    = 8'h00;
    localparam logic        CARRY_RST  = 1'h0;
    localparam logic        TO_N_RST   = 1'h1;
    localparam logic        PD_N_RST   = 1'h1;
    localparam logic        WAKE_RST   = 1'h0;

    // ************************************************************
    // Sequencer states
    // ************************************************************
    typedef enum logic [1:0] {
        RRS_RUN,
        RRS_SECOND,
        RRS_SLEEP
    } rrs_state_t;

endpackage

// *** rtl/rrs_exec.sv ***
/*
 * Execution logic for return-with-literal, rotate left, rotate right
 * and sleep. Assumes instruction, file read data and stack top arrive
 * synchronous to clk, and that the file read is combinational on
 * file_raddr within the same cycle.
 */
// What this block does
// - Return loads literal into accumulator, flags untouched
// - Return pops stack into pointer, two cycles
// - Rotate left through carry, d picks destination
// - Rotate right through carry, d picks destination
// - Sleep sets timeout flag, clears power-down flag
// - Sleep leaves pin-change wake flag unchanged
// - Sleep halts oscillator until wake or reset
`timescale 1ns/10ps

module rrs_exec
    import rrs_pkg::*;
#(
    parameter int unsigned PTR_W = rrs_pkg::IP_W
) (
    input  wire logic                          clk,
    input  wire logic                          reset,
    input  wire logic                          instr_valid,
    input  wire logic [rrs_pkg::INSTR_W-1:0]   instr,
    output logic                               instr_ready,
    output logic      [rrs_pkg::FADDR_W-1:0]   file_raddr,
    input  wire logic [rrs_pkg::DATA_W-1:0]    file_rdata,
    input  wire logic [PTR_W-1:0]              stack_top_entry,
    input  wire logic                          wake_up,
    input  wire logic                          pin_change_event,
    input  wire logic                          wake_flag_clear,
    output logic      [rrs_pkg::DATA_W-1:0]    accumulator,
    output logic                               carry,
    output logic      [PTR_W-1:0]              instruction_pointer,
    output logic                               ip_load,
    output logic                               stack_pop,
    output logic                               file_we,
    output logic      [rrs_pkg::FADDR_W-1:0]   file_waddr,
    output logic      [rrs_pkg::DATA_W-1:0]    file_wdata,
    output logic                               timeout_flag_n,
    output logic                               sleep_entered_flag_n,
    output logic                               pin_change_wake_flag,
    output logic                               watchdog_counter_clear,
    output logic                               prescaler_clear,
    output logic                               oscillator_stopped
);
    import rrs_pkg::*;

    // ************************************************************
    // Decode
    // ************************************************************
    rrs_state_t          state_q, state_d;
    logic [DATA_W-1:0]   acc_q, acc_d;
    logic                carry_q, carry_d;
    logic [PTR_W-1:0]    ip_q, ip_d;
    logic                ip_load_q, ip_load_d;
    logic                we_q, we_d;
    logic [FADDR_W-1:0]  waddr_q, waddr_d;
    logic [DATA_W-1:0]   wdata_q, wdata_d;
    logic                to_n_q, to_n_d;
    logic                pd_n_q, pd_n_d;
    logic                wake_q, wake_d;
    logic                wdt_clr_q, wdt_clr_d;
    logic                accept;
    logic                is_ret;
    logic                is_rot_l;
    logic                is_rot;
    logic                is_sleep;
    logic                to_file;
    logic [DATA_W-1:0]   rot_result;
    logic                rot_carry;

    // Ready only while running; second return cycle and sleep stall
    assign instr_ready = (state_q == RRS_RUN);
    assign accept      = instr_valid && instr_ready;
    assign is_ret      = (instr[INSTR_W-1:RET_OP_LSB] == RET_OP);
    assign is_rot_l    = (instr[INSTR_W-1:ROT_OP_LSB] == ROT_L_OP);
    assign is_rot      = is_rot_l ||
                         (instr[INSTR_W-1:ROT_OP_LSB] == ROT_R_OP);
    assign is_sleep    = (instr == SLEEP_OP);
    assign to_file     = instr[DEST_BIT];
    assign file_raddr  = instr[FADDR_MSB:0];

    rrs_rotate #(
        .W         (DATA_W)
    ) u_rotate (
        .data_in   (file_rdata),
        .carry_in  (carry_q),
        .left      (is_rot_l),
        .result    (rot_result),
        .carry_out (rot_carry)
    );

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        state_d   = state_q;
        acc_d     = acc_q;
        carry_d   = carry_q;
        ip_d      = ip_q;
        ip_load_d = 1'b0;
        we_d      = 1'b0;
        waddr_d   = waddr_q;
        wdata_d   = wdata_q;
        to_n_d    = to_n_q;
        pd_n_d    = pd_n_q;
        wdt_clr_d = 1'b0;
        // Set wins over clear; sleep itself never touches this flag
        wake_d    = (wake_q && !wake_flag_clear) || pin_change_event;
        unique case (state_q)
            RRS_RUN: begin
                if (accept && is_ret) begin
                    acc_d     = instr[LIT_MSB:0];
                    ip_d      = stack_top_entry;
                    ip_load_d = 1'b1;
                    state_d   = RRS_SECOND;
                end else if (accept && is_rot) begin
                    carry_d = rot_carry;
                    if (to_file) begin
                        we_d    = 1'b1;
                        waddr_d = instr[FADDR_MSB:0];
                        wdata_d = rot_result;
                    end else begin
                        acc_d = rot_result;
                    end
                end else if (accept && is_sleep) begin
                    to_n_d    = 1'b1;
                    pd_n_d    = 1'b0;
                    wdt_clr_d = 1'b1;
                    state_d   = RRS_SLEEP;
                end
            end
            RRS_SECOND: begin
                state_d = RRS_RUN;
            end
            RRS_SLEEP: begin
                // Oscillator stays stopped until the wake request
                if (wake_up) begin
                    state_d = RRS_RUN;
                end
            end
            default: begin
                state_d = RRS_RUN;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q   <= RRS_RUN;
            acc_q     <= ACC_RST;
            carry_q   <= CARRY_RST;
            ip_q      <= '0;
            ip_load_q <= 1'b0;
            we_q      <= 1'b0;
            waddr_q   <= '0;
            wdata_q   <= '0;
            to_n_q    <= TO_N_RST;
            pd_n_q    <= PD_N_RST;
            wake_q    <= WAKE_RST;
            wdt_clr_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            acc_q     <= acc_d;
            carry_q   <= carry_d;
            ip_q      <= ip_d;
            ip_load_q <= ip_load_d;
            we_q      <= we_d;
            waddr_q   <= waddr_d;
            wdata_q   <= wdata_d;
            to_n_q    <= to_n_d;
            pd_n_q    <= pd_n_d;
            wake_q    <= wake_d;
            wdt_clr_q <= wdt_clr_d;
        end
    end

    assign accumulator            = acc_q;
    assign carry                  = carry_q;
    assign instruction_pointer    = ip_q;
    assign ip_load                = ip_load_q;
    assign stack_pop              = ip_load_q;
    assign file_we                = we_q;
    assign file_waddr             = waddr_q;
    assign file_wdata             = wdata_q;
    assign timeout_flag_n         = to_n_q;
    assign sleep_entered_flag_n   = pd_n_q;
    assign pin_change_wake_flag   = wake_q;
    // Both clears share one pulse so they can never drift apart
    assign watchdog_counter_clear = wdt_clr_q;
    assign prescaler_clear        = wdt_clr_q;
    assign oscillator_stopped     = (state_q == RRS_SLEEP);

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_ret_second;
        (ip_load && !instr_ready) ##1 instr_ready;
    endsequence

    sequence s_sleep_entry;
        oscillator_stopped && !instr_ready && timeout_flag_n;
    endsequence

    AST_RET_ACC: assert property (@(posedge clk) disable iff (reset)
        accept && is_ret |=> accumulator == $past(instr[LIT_MSB:0])
                             && carry == $past(carry))
        else $error("return did not load literal or touched carry");

    AST_RET_PTR: assert property (@(posedge clk) disable iff (reset)
        accept && is_ret |=>
            instruction_pointer == $past(stack_top_entry) ##0 s_ret_second)
        else $error("return pointer load or two-cycle timing wrong");

    AST_ROT_L: assert property (@(posedge clk) disable iff (reset)
        accept && is_rot_l |=> carry == $past(file_rdata[DATA_W-1])
            && ($past(to_file)
                ? (file_we && file_wdata ==
                   {$past(file_rdata[DATA_W-2:0]), $past(carry)})
                : (!file_we && accumulator ==
                   {$past(file_rdata[DATA_W-2:0]), $past(carry)})))
        else $error("rotate left result or carry wrong");

    AST_ROT_R: assert property (@(posedge clk) disable iff (reset)
        accept && is_rot && !is_rot_l |=> carry == $past(file_rdata[0])
            && ($past(to_file)
                ? (file_we && file_wdata ==
                   {$past(carry), $past(file_rdata[DATA_W-1:1])})
                : (!file_we && accumulator ==
                   {$past(carry), $past(file_rdata[DATA_W-1:1])})))
        else $error("rotate right result or carry wrong");

    AST_SLEEP_FLAGS: assert property (@(posedge clk)
        disable iff (reset)
        accept && is_sleep |=> timeout_flag_n && !sleep_entered_flag_n)
        else $error("sleep status flags wrong");

    AST_WAKE_KEEP: assert property (@(posedge clk) disable iff (reset)
        accept && is_sleep && !pin_change_event && !wake_flag_clear
            |=> $stable(pin_change_wake_flag))
        else $error("sleep changed pin-change wake flag");

    AST_SLEEP_HALT: assert property (@(posedge clk)
        disable iff (reset)
        accept && is_sleep ##1 !wake_up |=> s_sleep_entry)
        else $error("sleep did not hold oscillator stopped");

    AST_WDT_CLR: assert property (@(posedge clk) disable iff (reset)
        accept && is_sleep |=> watchdog_counter_clear && prescaler_clear
                               ##1 !watchdog_counter_clear)
        else $error("sleep did not pulse watchdog clears once");

endmodule // rrs_exec

// *** rtl/rrs_rotate.sv ***
/*
 * One-bit rotate through carry, left or right.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/10ps

module rrs_rotate #(
    parameter int unsigned W = 8
) (
    input  wire logic [W-1:0] data_in,
    input  wire logic         carry_in,
    input  wire logic         left,
    output logic      [W-1:0] result,
    output logic              carry_out
);

    always_comb begin
        if (left) begin
            result    = {data_in[W-2:0], carry_in};
            carry_out = data_in[W-1];
        end else begin
            result    = {carry_in, data_in[W-1:1]};
            carry_out = data_in[0];
        end
    end

endmodule // rrs_rotate

// *** testbench/rrs_exec_test.sv ***
/*
 * Self-checking bench for rrs_exec: rotate, return and sleep sequences.
 * Assumes the block sits alone; the bench plays file, stack and wake.
 */
`timescale 1ns/10ps

module rrs_exec_test;
    import rrs_pkg::*;

    // ************************************************************
    // Signals
    // ************************************************************
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        instr_valid = 1'b0;
    logic [11:0] instr = 12'h000;
    logic        instr_ready;
    logic [4:0]  file_raddr;
    logic [7:0]  file_rdata = 8'h00;
    logic [9:0]  stack_top_entry = 10'h000;
    logic        wake_up = 1'b0;
    logic        pin_change_event = 1'b0;
    logic        wake_flag_clear = 1'b0;
    logic [7:0]  accumulator;
    logic        carry;
    logic [9:0]  instruction_pointer;
    logic        ip_load;
    logic        stack_pop;
    logic        file_we;
    logic [4:0]  file_waddr;
    logic [7:0]  file_wdata;
    logic        timeout_flag_n;
    logic        sleep_entered_flag_n;
    logic        pin_change_wake_flag;
    logic        watchdog_counter_clear;
    logic        prescaler_clear;
    logic        oscillator_stopped;
    logic [4:0]  seen_raddr;
    logic        exp_c = 1'b0;
    logic [7:0]  exp_a;
    logic [7:0]  res;
    logic [7:0]  pat [8] = '{8'hE6, 8'hE6, 8'h81, 8'h81,
                             8'h00, 8'hFF, 8'h7F, 8'h01};
    int          n_fail = 0;
    int          n_tests = 0;

    always #5 clk = ~clk;

    rrs_exec u_dut (
        .clk                    (clk),
        .reset                  (reset),
        .instr_valid            (instr_valid),
        .instr                  (instr),
        .instr_ready            (instr_ready),
        .file_raddr             (file_raddr),
        .file_rdata             (file_rdata),
        .stack_top_entry        (stack_top_entry),
        .wake_up                (wake_up),
        .pin_change_event       (pin_change_event),
        .wake_flag_clear        (wake_flag_clear),
        .accumulator            (accumulator),
        .carry                  (carry),
        .instruction_pointer    (instruction_pointer),
        .ip_load                (ip_load),
        .stack_pop              (stack_pop),
        .file_we                (file_we),
        .file_waddr             (file_waddr),
        .file_wdata             (file_wdata),
        .timeout_flag_n         (timeout_flag_n),
        .sleep_entered_flag_n   (sleep_entered_flag_n),
        .pin_change_wake_flag   (pin_change_wake_flag),
        .watchdog_counter_clear (watchdog_counter_clear),
        .prescaler_clear        (prescaler_clear),
        .oscillator_stopped     (oscillator_stopped)
    );

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Called at a falling edge; leaves valid high so calls run back to back
    task automatic exec(input logic [11:0] word);
        instr_valid = 1'b1;
        instr       = word;
        #1 seen_raddr = file_raddr;
        @(negedge clk);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Whole run is under fifty cycles; this bound is generous
    initial begin
        repeat (3000) @(posedge clk);
        n_fail++;
        $display("watchdog expired");
        conclude();
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        chk_vec(accumulator, 16'h0000);
        chk_bit(timeout_flag_n, 1'b1);
        chk_bit(sleep_entered_flag_n, 1'b1);
        chk_bit(oscillator_stopped, 1'b0);
        chk_bit(instr_ready, 1'b1);
        $display("test reset done");
        // Back to back rotates over both directions and destinations
        for (int i = 0; i < 8; i++) begin
            file_rdata = pat[i];
            exp_a = accumulator;
            if (i[0]) begin
                res = {pat[i][6:0], exp_c};
                exp_c = pat[i][7];
            end else begin
                res = {exp_c, pat[i][7:1]};
                exp_c = pat[i][0];
            end
            exec({4'b0011, 1'b0, i[0], i[1], 5'(i * 4 + 3)});
            chk_vec(seen_raddr, 16'(i * 4 + 3));
            chk_bit(carry, exp_c);
            chk_bit(file_we, i[1]);
            if (i[1]) begin
                chk_vec(file_wdata, res);
                chk_vec(file_waddr, 16'(i * 4 + 3));
                chk_vec(accumulator, exp_a);
            end else begin
                chk_vec(accumulator, res);
            end
        end
        $display("test rotate done");
        // Return, then a second return offered in the dead cycle
        stack_top_entry = 10'h2B3;
        exec(12'h8FF);
        chk_vec(accumulator, 16'h00FF);
        chk_bit(carry, exp_c);
        chk_vec(instruction_pointer, 16'h02B3);
        chk_bit(ip_load, 1'b1);
        chk_bit(stack_pop, 1'b1);
        chk_bit(instr_ready, 1'b0);
        stack_top_entry = 10'h14C;
        exec(12'h800);
        chk_vec(accumulator, 16'h00FF);
        chk_bit(ip_load, 1'b0);
        chk_bit(instr_ready, 1'b1);
        @(negedge clk);
        instr_valid = 1'b0;
        chk_vec(accumulator, 16'h0000);
        chk_vec(instruction_pointer, 16'h014C);
        @(negedge clk);
        $display("test return done");
        // Sleep with the wake flag low, then high
        for (int w = 0; w < 2; w++) begin
            pin_change_event = w[0];
            @(negedge clk);
            pin_change_event = 1'b0;
            exp_a = accumulator;
            exec(12'h003);
            instr = 12'h855;
            chk_bit(timeout_flag_n, 1'b1);
            chk_bit(sleep_entered_flag_n, 1'b0);
            chk_bit(pin_change_wake_flag, w[0]);
            chk_bit(watchdog_counter_clear, 1'b1);
            chk_bit(prescaler_clear, 1'b1);
            chk_bit(oscillator_stopped, 1'b1);
            chk_bit(instr_ready, 1'b0);
            @(negedge clk);
            chk_bit(watchdog_counter_clear, 1'b0);
            repeat (3) @(negedge clk);
            chk_vec(accumulator, exp_a);
            chk_bit(oscillator_stopped, 1'b1);
            instr_valid = 1'b0;
            wake_up     = 1'b1;
            @(negedge clk);
            wake_up = 1'b0;
            chk_bit(oscillator_stopped, 1'b0);
            chk_bit(instr_ready, 1'b1);
            chk_bit(pin_change_wake_flag, w[0]);
        end
        // Event and clear together: the set must win
        wake_flag_clear  = 1'b1;
        pin_change_event = 1'b1;
        @(negedge clk);
        pin_change_event = 1'b0;
        chk_bit(pin_change_wake_flag, 1'b1);
        @(negedge clk);
        wake_flag_clear = 1'b0;
        chk_bit(pin_change_wake_flag, 1'b0);
        $display("test sleep done");
        conclude();
    end

endmodule // rrs_exec_test
